// File: design/sdr_ctrl.sv
// Controller end: takes one-line orders from a plain port and drives legal command timing.
`timescale 1ns/1ns
module sdr_ctrl
    import sdr_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [3:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    sdr_if.ctl pins
);
    // ------------------------------------------------------------
    // Orders: write to 0x0 issues {cmd[2:0], ba, dqm, addr} as bits
    // [18:16],[15:14],[12],[10:0]; write to 0x4 sets data; read 0x8 is status, 0xc last dq.
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        SDR_C_IDLE = 2'h1,
        SDR_C_WAIT = 2'h2
    } sdr_cs_t;
    sdr_cs_t st, next_st;
    logic [2:0] cmd, next_cmd;
    logic [BANK_W-1:0] ba, next_ba;
    logic [ADDR_W-1:0] a, next_a;
    logic dqm, next_dqm;
    logic [DATA_W-1:0] dout, next_dout;
    logic [DATA_W-1:0] cap, next_cap;
    logic [CNT_W-1:0] gap, next_gap;
    logic [31:0] next_rdata;
    logic busy;
    assign busy = gap != CNT_ZERO;
    always_comb begin
        next_st = st;
        next_cmd = SDR_NOP;
        next_ba = ba;
        next_a = a;
        next_dqm = dqm;
        next_dout = dout;
        next_cap = pins.dq;
        next_gap = busy ? gap - 4'h1 : gap;
        next_rdata = 32'h0;
        if (wr && addr == 4'h4) begin
            next_dout = wdata;
        end
        if (wr && addr == 4'h0 && !busy) begin
            next_cmd = wdata[18:16];
            next_ba = wdata[15:14];
            next_dqm = wdata[12];
            next_a = wdata[10:0];
            if (wdata[18:16] == SDR_ACTIVE) begin
                next_gap = CNT_W'(TRC_CYC > TRCD_CYC ? TRC_CYC : TRCD_CYC);
            end else if (wdata[18:16] == SDR_PRE) begin
                next_gap = CNT_W'(TRP_CYC);
            end
        end
        next_st = busy ? SDR_C_WAIT : SDR_C_IDLE;
        if (rd) begin
            case (addr)
                4'h8: next_rdata = {30'h0, busy, st == SDR_C_IDLE};
                4'hc: next_rdata = cap;
                default: next_rdata = 32'h0;
            endcase
        end
    end
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            st <= SDR_C_IDLE;
            cmd <= SDR_NOP;
            ba <= '0;
            a <= '0;
            dqm <= 1'b0;
            dout <= '0;
            cap <= '0;
            gap <= '0;
            rdata <= 32'h0;
        end else begin
            st <= next_st;
            cmd <= next_cmd;
            ba <= next_ba;
            a <= next_a;
            dqm <= next_dqm;
            dout <= next_dout;
            cap <= next_cap;
            gap <= next_gap;
            rdata <= next_rdata;
        end
    end
    // Data is driven only in the write cycle; spacing from reads is software's job.
    assign pins.cs_n = 1'b0;
    assign pins.cmd = cmd;
    assign pins.ba = ba;
    assign pins.addr = a;
    assign pins.dqm = dqm;
    assign pins.dq_ctl_o = dout;
    assign pins.dq_ctl_oe = cmd == SDR_WRITE;
endmodule : sdr_ctrl

// File: design/sdr_device.sv
// Device end: bank state, mode register and the read burst data path.
// Behaviour
// - Write burst mode one makes writes single-location; the device ignores that mode bit and has no write path.
// - Controller never programs test or reserved modes.
// - Controller picks latency allowed at clock rate.
// - Controller opens row before read or write.
// - Read waits the activate-to-column delay.
// - Same-bank activate needs precharge and row cycle.
// - Activates to different banks spaced by minimum.
// - Read auto precharge closes row after burst.
// - First word after latency, then one per edge.
// - Finished burst releases data pins.
// - Full-page read wraps to column zero forever.
// - New read truncates; data stays continuous.
// - Read accepted on any clock after read.
// - Write follows last read word, avoiding contention.
// - Mask two clocks before write silences output.
// - Registered write keeps data pins released.
// - Controller drops mask before write edge.
// - Precharge truncates read without auto precharge.
// - Controller waits precharge time after precharge.
// - Timed precharge equals auto precharge result.
// - Burst terminate stops read at latency minus one.
// - Latency of two or three clocks supported.
`timescale 1ns/1ns
module sdr_device
    import sdr_pkg::*;
#(
    parameter int MEM_DEPTH = 256
) (
    input wire logic sys_clk,
    input wire logic rst,
    sdr_if.dev pins,
    output logic [ADDR_W-1:0] mode_reg,
    output logic [NUM_BANKS-1:0] bank_open,
    output logic write_seen
);
    // ------------------------------------------------------------
    // Types and state
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        SDR_RD_IDLE = 2'h1,
        SDR_RD_BURST = 2'h2
    } sdr_rd_t;
    localparam int PIPE = 4;
    sdr_rd_t rd_state, next_rd_state;
    logic [ADDR_W-1:0] next_mode_reg;
    logic [NUM_BANKS-1:0] next_bank_open;
    logic [BANK_W-1:0] rd_bank, next_rd_bank;
    logic rd_ap, next_rd_ap;
    logic [COL_W-1:0] rd_start, next_rd_start;
    logic [COL_W-1:0] rd_cnt, next_rd_cnt;
    logic [PIPE-1:0] vpipe, next_vpipe;
    logic [DATA_W-1:0] dpipe [PIPE], next_dpipe [PIPE];
    logic [1:0] dqm_pipe, next_dqm_pipe;
    logic next_write_seen;
    logic [DATA_W-1:0] mem [MEM_DEPTH];
    sdr_cmd_t cmd;
    logic [2:0] cl;
    logic [COL_W-1:0] blen;
    logic full_page;
    logic [COL_W-1:0] col;
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [COL_W-1:0] burst_col(input logic [COL_W-1:0] start, input logic [COL_W-1:0] idx,
                                                   input logic [2:0] bl, input logic il);
        logic [COL_W-1:0] m;
        m = (bl == BL_1) ? 8'h00 : (bl == BL_2) ? 8'h01 : (bl == BL_4) ? 8'h03 : (bl == BL_8) ? 8'h07 : 8'hff;
        if (il && bl != BL_PAGE) begin
            burst_col = (start & ~m) | ((start ^ idx) & m);
        end else begin
            burst_col = (start & ~m) | ((start + idx) & m);
        end
    endfunction : burst_col

    assign cmd = pins.cs_n ? SDR_NOP : sdr_cmd_t'(pins.cmd);
    assign cl = mode_reg[CL_POS+:3];
    assign full_page = mode_reg[BL_POS+:3] == BL_PAGE;
    assign blen = (mode_reg[BL_POS+:3] == BL_1) ? 8'h01 : (mode_reg[BL_POS+:3] == BL_2) ? 8'h02 :
                  (mode_reg[BL_POS+:3] == BL_4) ? 8'h04 : 8'h08;
    assign col = burst_col(rd_start, rd_cnt, mode_reg[BL_POS+:3], mode_reg[BT_POS]);
    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        next_rd_state = rd_state;
        next_mode_reg = mode_reg;
        next_bank_open = bank_open;
        next_rd_bank = rd_bank;
        next_rd_ap = rd_ap;
        next_rd_start = rd_start;
        next_rd_cnt = rd_cnt;
        next_write_seen = 1'b0;
        next_dqm_pipe = {dqm_pipe[0], pins.dqm};
        next_vpipe = {vpipe[PIPE-2:0], 1'b0};
        next_dpipe[0] = mem[int'({rd_bank, col}) % MEM_DEPTH];
        for (int i = 1; i < PIPE; i++) begin
            next_dpipe[i] = dpipe[i-1];
        end
        if (rd_state == SDR_RD_BURST) begin
            next_vpipe[0] = 1'b1;
            next_rd_cnt = rd_cnt + 8'h01;
            if (!full_page && rd_cnt == blen - 8'h01) begin
                next_rd_state = SDR_RD_IDLE;
                if (rd_ap) begin
                    next_bank_open[rd_bank] = 1'b0;
                end
            end
        end
        case (cmd)
            SDR_LMR: begin
                next_mode_reg = pins.addr;
            end
            SDR_ACTIVE: begin
                next_bank_open[pins.ba] = 1'b1;
            end
            SDR_PRE: begin
                if (pins.addr[AP_BIT]) begin
                    next_bank_open = '0;
                end else begin
                    next_bank_open[pins.ba] = 1'b0;
                end
                if (pins.addr[AP_BIT] || pins.ba == rd_bank) begin
                    next_rd_state = SDR_RD_IDLE;
                end
            end
            SDR_BST: begin
                next_rd_state = SDR_RD_IDLE;
            end
            SDR_READ: begin
                if (bank_open[pins.ba]) begin
                    if (rd_state == SDR_RD_BURST && rd_ap && rd_bank != pins.ba) begin
                        next_bank_open[rd_bank] = 1'b0;
                    end
                    next_rd_state = SDR_RD_BURST;
                    next_rd_bank = pins.ba;
                    next_rd_ap = pins.addr[AP_BIT];
                    next_rd_start = pins.addr[COL_W-1:0];
                    next_rd_cnt = '0;
                end
            end
            SDR_WRITE: begin
                next_write_seen = 1'b1;
                next_rd_state = SDR_RD_IDLE;
                next_vpipe = '0;
                if (rd_state == SDR_RD_BURST && rd_ap) begin
                    next_bank_open[rd_bank] = 1'b0;
                end
            end
            default: begin
            end
        endcase
    end
    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rd_state <= SDR_RD_IDLE;
            mode_reg <= MODE_RESET;
            bank_open <= '0;
            rd_bank <= '0;
            rd_ap <= 1'b0;
            rd_start <= '0;
            rd_cnt <= '0;
            vpipe <= '0;
            dqm_pipe <= '0;
            write_seen <= 1'b0;
            for (int i = 0; i < PIPE; i++) begin
                dpipe[i] <= '0;
            end
        end else begin
            rd_state <= next_rd_state;
            mode_reg <= next_mode_reg;
            bank_open <= next_bank_open;
            rd_bank <= next_rd_bank;
            rd_ap <= next_rd_ap;
            rd_start <= next_rd_start;
            rd_cnt <= next_rd_cnt;
            vpipe <= next_vpipe;
            dqm_pipe <= next_dqm_pipe;
            write_seen <= next_write_seen;
            for (int i = 0; i < PIPE; i++) begin
                dpipe[i] <= next_dpipe[i];
            end
        end
    end
    // Storage holds a fixed pattern so reads are predictable without a write path.
    always_ff @(posedge sys_clk) begin
        for (int i = 0; i < MEM_DEPTH; i++) begin
            mem[i] <= {16'h5a00, 16'(i)};
        end
    end
    // ------------------------------------------------------------
    // Output drive
    // ------------------------------------------------------------
    // The burst engine steps at the read edge, so word k lands at edge n+cl+k.
    always_comb begin
        pins.dq_dev_o = (cl == CL_3) ? dpipe[1] : dpipe[0];
        pins.dq_dev_oe = ((cl == CL_3) ? vpipe[1] : vpipe[0]) && !dqm_pipe[1];
    end
endmodule : sdr_device

// File: design/sdr_if.sv
// Interface joining the controller and the DRAM device command, address and data pins.
`timescale 1ns/1ns
interface sdr_if;
    import sdr_pkg::*;
    logic cs_n;
    logic [2:0] cmd;
    logic [BANK_W-1:0] ba;
    logic [ADDR_W-1:0] addr;
    logic dqm;
    logic [DATA_W-1:0] dq_ctl_o;
    logic dq_ctl_oe;
    logic [DATA_W-1:0] dq_dev_o;
    logic dq_dev_oe;
    logic [DATA_W-1:0] dq;
    assign dq = dq_dev_oe ? dq_dev_o : (dq_ctl_oe ? dq_ctl_o : '0);
    modport ctl (output cs_n, cmd, ba, addr, dqm, dq_ctl_o, dq_ctl_oe, input dq);
    modport dev (input cs_n, cmd, ba, addr, dqm, dq_ctl_o, dq_ctl_oe, output dq_dev_o, dq_dev_oe);
endinterface : sdr_if

// File: design/sdr_pkg.sv
// Package of shared constants and types for the synchronous DRAM read path.
package sdr_pkg;
    // ------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------
    localparam int DATA_W = 32;
    localparam int ROW_W = 11;
    localparam int COL_W = 8;
    localparam int BANK_W = 2;
    localparam int NUM_BANKS = 4;
    localparam int ADDR_W = 11;
    localparam int AP_BIT = 10;
    // ------------------------------------------------------------
    // Mode register fields
    // ------------------------------------------------------------
    localparam int BL_POS = 0;
    localparam int BT_POS = 3;
    localparam int CL_POS = 4;
    localparam int WBM_POS = 9;
    localparam logic [2:0] BL_1 = 3'h0;
    localparam logic [2:0] BL_2 = 3'h1;
    localparam logic [2:0] BL_4 = 3'h2;
    localparam logic [2:0] BL_8 = 3'h3;
    localparam logic [2:0] BL_PAGE = 3'h7;
    localparam logic [2:0] CL_2 = 3'h2;
    localparam logic [2:0] CL_3 = 3'h3;
    localparam logic [ADDR_W-1:0] MODE_RESET = 11'h032;
    // ------------------------------------------------------------
    // Timing, clock 10 MHz
    // ------------------------------------------------------------
    localparam int CLK_NS = 100;
    localparam int TRCD_NS = 20;
    localparam int TRC_NS = 70;
    localparam int TRRD_NS = 15;
    localparam int TRP_NS = 20;
    localparam int TRCD_CYC = (TRCD_NS + CLK_NS - 1) / CLK_NS;
    localparam int TRC_CYC = (TRC_NS + CLK_NS - 1) / CLK_NS;
    localparam int TRRD_CYC = (TRRD_NS + CLK_NS - 1) / CLK_NS;
    localparam int TRP_CYC = (TRP_NS + CLK_NS - 1) / CLK_NS;
    localparam int CNT_W = 4;
    localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
    // ------------------------------------------------------------
    // Commands {ras_n, cas_n, we_n}
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        SDR_NOP = 3'h7,
        SDR_ACTIVE = 3'h3,
        SDR_READ = 3'h5,
        SDR_WRITE = 3'h4,
        SDR_BST = 3'h6,
        SDR_PRE = 3'h2,
        SDR_REF = 3'h1,
        SDR_LMR = 3'h0
    } sdr_cmd_t;
endpackage : sdr_pkg

// File: testbench/sdr_activate_read_path_tb.sv
// Bench: controller joined to a device, plus a second device driven directly.
`timescale 1ns/1ns
module sdr_activate_read_path_tb;
    import sdr_pkg::*;
    // ------------------------------------------------------------
    // Harness
    // ------------------------------------------------------------
    localparam int DEPTH = 1024;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] addr = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [31:0] rdata;
    logic [ADDR_W-1:0] mode_b;
    logic [NUM_BANKS-1:0] open_b;
    logic wseen_b;
    logic [1:0] rb;
    logic [7:0] rc;
    logic [31:0] rv;
    logic [32:0] sched [0:255];
    int error_cnt = 0;
    int comparisons = 0;
    int cyc = 0;
    int t_cmd;
    sdr_if if_a();
    sdr_if if_b();
    always #50 sys_clk = ~sys_clk;
    sdr_ctrl sdr_ctrl_i (.sys_clk(sys_clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .pins(if_a.ctl));
    sdr_device #(.MEM_DEPTH(DEPTH)) sdr_device_i (.sys_clk(sys_clk), .rst(rst), .pins(if_a.dev),
        .mode_reg(), .bank_open(), .write_seen());
    sdr_device #(.MEM_DEPTH(DEPTH)) sdr_device_i_b (.sys_clk(sys_clk), .rst(rst), .pins(if_b.dev),
        .mode_reg(mode_b), .bank_open(open_b), .write_seen(wseen_b));
    sdr_asserts #(.MEM_DEPTH(DEPTH)) sdr_asserts_i (.sys_clk(sys_clk), .rst(rst), .cs_n(if_a.cs_n),
        .cmd(if_a.cmd), .ba(if_a.ba), .addr(if_a.addr), .dqm(if_a.dqm), .dq_dev_o(if_a.dq_dev_o),
        .dq_dev_oe(if_a.dq_dev_oe));
    task automatic check(input string what, input logic [32:0] seen, input logic [32:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic final_report;
        $display("comparisons %0d errors %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : final_report
    // Order word: command in bits 18 to 16, bank in 15 to 14, mask in 12, address in 10 to 0.
    function automatic logic [31:0] order(input sdr_cmd_t c, input logic [1:0] b, input logic [10:0] a,
        input logic m = 1'b0);
        return {13'h0, 3'(c), b, 1'b0, m, 1'b0, a};
    endfunction : order
    function automatic logic [32:0] word_at(input logic [1:0] b, input logic [7:0] col, input int k, input bit pg);
        logic [7:0] c;
        c = pg ? col + 8'(k) : {col[7:2], col[1:0] + 2'(k)};
        return {1'b1, 16'h5a00, 16'({b, c} % DEPTH)};
    endfunction : word_at
    task automatic expect_rd(input int t, input logic [1:0] b, input logic [7:0] col, input int n, input int cl,
        input bit pg);
        for (int k = 0; k < n; k++) sched[8'(t + cl + k)] = word_at(b, col, k, pg);
    endtask : expect_rd
    task automatic go(input sdr_cmd_t c, input logic [1:0] b, input logic [10:0] a, input logic m = 1'b0);
        @(posedge sys_clk);
        t_cmd = cyc + 1;
        if_b.cmd <= c;
        if_b.ba <= b;
        if_b.addr <= a;
        if_b.dqm <= m;
    endtask : go
    task automatic idle(input int n);
        repeat (n) go(SDR_NOP, 2'h0, 11'h0);
    endtask : idle
    task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge sys_clk);
        wr <= 1'b0;
    endtask : reg_wr
    // Read data stand only in the cycle after the strobe, so they are taken at the edge that ends it.
    task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge sys_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge sys_clk);
        rd <= 1'b0;
        @(posedge sys_clk);
        d = rdata;
    endtask : reg_rd
    // Every cycle the direct device's pins are held against the expected schedule.
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (!rst) check("dq", {if_b.dq_dev_oe, if_b.dq_dev_oe ? if_b.dq_dev_o : 32'h0}, sched[cyc[7:0]]);
        sched[cyc[7:0]] <= 33'h0;
        if (cyc == 3000) begin
            error_cnt++;
            final_report();
        end
    end
    initial begin
        foreach (sched[i]) sched[i] = 33'h0;
        if_b.cs_n = 1'b0;
        if_b.cmd = SDR_NOP;
        if_b.ba = 2'h0;
        if_b.addr = 11'h0;
        if_b.dqm = 1'b0;
        if_b.dq_ctl_o = 32'h0;
        if_b.dq_ctl_oe = 1'b0;
        void'($urandom(32'hf4a0));
        repeat (8) @(posedge sys_clk);
        rst <= 1'b0;
        idle(1);
        check("open", open_b, 4'h0);
        reg_wr(4'h0, order(SDR_ACTIVE, 2'h1, 11'h005));
        repeat (10) begin
            idle(3);
            reg_wr(4'h0, order(SDR_READ, 2'h1, 11'($urandom_range(0, 255))));
        end
        reg_rd(4'h8, rv);
        check("status", rv, 32'h1);
        idle(4);
        // Controller path: terminate, precharge cut, latency two, mask before write, full page.
        reg_wr(4'h0, order(SDR_READ, 2'h1, 11'h010));
        reg_wr(4'h0, order(SDR_BST, 2'h1, 11'h000));
        idle(4);
        reg_wr(4'h0, order(SDR_READ, 2'h1, 11'h020));
        reg_wr(4'h0, order(SDR_PRE, 2'h1, 11'h000));
        idle(4);
        reg_wr(4'h0, order(SDR_LMR, 2'h0, 11'h022));
        reg_wr(4'h0, order(SDR_ACTIVE, 2'h2, 11'h007));
        reg_wr(4'h0, order(SDR_READ, 2'h2, 11'h030));
        idle(4);
        reg_wr(4'h0, order(SDR_READ, 2'h2, 11'h031));
        reg_wr(4'h0, order(SDR_NOP, 2'h2, 11'h000, 1'b1));
        reg_wr(4'h0, order(SDR_WRITE, 2'h2, 11'h031));
        idle(4);
        reg_wr(4'h0, order(SDR_PRE, 2'h0, 11'h400));
        reg_wr(4'h0, order(SDR_LMR, 2'h0, 11'h037));
        reg_wr(4'h0, order(SDR_ACTIVE, 2'h3, 11'h009));
        reg_wr(4'h0, order(SDR_READ, 2'h3, 11'h040));
        idle(6);
        reg_rd(4'hc, rv);
        check("dq capture", rv[31:16], 16'h5a00);
        reg_wr(4'h0, order(SDR_BST, 2'h3, 11'h000));
        reg_rd(4'hf, rv);
        check("unmapped", rv, 32'h0);
        idle(4);
        go(SDR_READ, 2'h2, 11'h004);
        idle(6);
        for (int m = 0; m < 2; m++) begin
            go(SDR_PRE, 2'h0, 11'h400);
            go(SDR_LMR, 2'h0, m ? 11'h232 : 11'h022);
            idle(2);
            check("mode", mode_b, m ? 11'h232 : 11'h022);
            for (int bk = 0; bk < 4; bk++) go(SDR_ACTIVE, 2'(bk), 11'($urandom));
            idle(2);
            check("open", open_b, 4'hf);
            repeat (12) begin
                rb = 2'($urandom);
                rc = 8'($urandom);
                go(SDR_READ, rb, {3'h0, rc});
                expect_rd(t_cmd, rb, rc, 4, m + 2, 0);
                idle($urandom_range(0, 4));
            end
            idle(6);
        end
        go(SDR_READ, 2'h1, 11'h405);
        expect_rd(t_cmd, 2'h1, 8'h05, 4, 3, 0);
        idle(9);
        check("auto pre", open_b, 4'hd);
        go(SDR_READ, 2'h2, 11'h009);
        expect_rd(t_cmd, 2'h2, 8'h09, 4, 3, 0);
        idle(3);
        go(SDR_PRE, 2'h2, 11'h000);
        idle(5);
        check("timed pre", open_b, 4'h9);
        go(SDR_READ, 2'h0, 11'h002);
        expect_rd(t_cmd, 2'h0, 8'h02, 1, 3, 0);
        idle(1);
        go(SDR_NOP, 2'h0, 11'h0, 1'b1);
        go(SDR_NOP, 2'h0, 11'h0, 1'b1);
        go(SDR_WRITE, 2'h0, 11'h002);
        idle(1);
        #1 check("write seen", wseen_b, 1'b1);
        go(SDR_PRE, 2'h0, 11'h400);
        go(SDR_LMR, 2'h0, 11'h037);
        go(SDR_ACTIVE, 2'h1, 11'h033);
        go(SDR_READ, 2'h1, 11'h0fe);
        expect_rd(t_cmd, 2'h1, 8'hfe, 9, 3, 1);
        idle(8);
        go(SDR_BST, 2'h1, 11'h000);
        idle(6);
        go(SDR_READ, 2'h1, 11'h07f);
        expect_rd(t_cmd, 2'h1, 8'h7f, 5, 3, 1);
        idle(4);
        go(SDR_PRE, 2'h1, 11'h000);
        idle(6);
        check("pre cut", open_b, 4'h0);
        final_report();
    end
endmodule : sdr_activate_read_path_tb

// File: testbench/sdr_asserts.sv
// Checker of device read timing on the pins between controller and device.
`timescale 1ns/1ns
module sdr_asserts
    import sdr_pkg::*;
#(
    parameter int MEM_DEPTH = 256
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic cs_n,
    input wire logic [2:0] cmd,
    input wire logic [BANK_W-1:0] ba,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic dqm,
    input wire logic [DATA_W-1:0] dq_dev_o,
    input wire logic dq_dev_oe
);
    // ------------------------------------------------------------
    // Mode and bank tracking
    // ------------------------------------------------------------
    // Auto precharge is not tracked, so reads must not reach a bank closed that way.
    logic [2:0] cl, bl, next_cl, next_bl;
    logic [NUM_BANKS-1:0] open_b, next_open_b;
    logic [BANK_W-1:0] rd_ba, next_rd_ba;
    wire logic is_nop = cs_n || cmd == SDR_NOP;
    wire logic rd_ok = !cs_n && cmd == SDR_READ && open_b[ba];
    always_comb begin
        next_cl = cl;
        next_bl = bl;
        next_open_b = open_b;
        next_rd_ba = rd_ba;
        if (!cs_n && cmd == SDR_LMR) begin
            next_cl = addr[CL_POS+:3];
            next_bl = addr[BL_POS+:3];
        end
        if (!cs_n && cmd == SDR_ACTIVE) next_open_b[ba] = 1'b1;
        if (!cs_n && cmd == SDR_PRE) next_open_b = addr[AP_BIT] ? '0 : open_b & ~(4'h1 << ba);
        if (rd_ok) next_rd_ba = ba;
    end
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cl <= MODE_RESET[CL_POS+:3];
            bl <= MODE_RESET[BL_POS+:3];
            open_b <= '0;
            rd_ba <= '0;
        end else begin
            cl <= next_cl;
            bl <= next_bl;
            open_b <= next_open_b;
            rd_ba <= next_rd_ba;
        end
    end
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);
    property p_rd_cl3;
        (rd_ok && cl == CL_3) ##1 (!dqm && cmd != SDR_WRITE) ##1 (cmd != SDR_WRITE) |=> dq_dev_oe &&
            dq_dev_o == {16'h5a00, 16'({$past(ba, 3), $past(addr[COL_W-1:0], 3)} % MEM_DEPTH)};
    endproperty
    a_rd_cl3: assert property (p_rd_cl3) else $error("first read word late or wrong");
    property p_rd_cl2;
        (rd_ok && cl == CL_2 && !dqm) ##1 (cmd != SDR_WRITE) |=> dq_dev_oe;
    endproperty
    a_rd_cl2: assert property (p_rd_cl2) else $error("latency two word missing");
    property p_release;
        (rd_ok && cl == CL_3 && bl == BL_4) ##1 is_nop [*6] |=> !dq_dev_oe;
    endproperty
    a_release: assert property (p_release) else $error("data pins held after burst");
    property p_page_run;
        (rd_ok && cl == CL_3 && bl == BL_PAGE) ##1 (is_nop && !dqm) [*8] |=> dq_dev_oe;
    endproperty
    a_page_run: assert property (p_page_run) else $error("full page burst stopped");
    property p_bst_stop;
        (!cs_n && cmd == SDR_BST && cl == CL_3) ##1 is_nop [*3] |-> !dq_dev_oe;
    endproperty
    a_bst_stop: assert property (p_bst_stop) else $error("burst terminate late");
    property p_pre_stop;
        (!cs_n && cmd == SDR_PRE && ba == rd_ba && cl == CL_3) ##1 is_nop [*3] |-> !dq_dev_oe;
    endproperty
    a_pre_stop: assert property (p_pre_stop) else $error("precharge cut late");
    property p_write_quiet;
        (!cs_n && cmd == SDR_WRITE) |=> !dq_dev_oe;
    endproperty
    a_write_quiet: assert property (p_write_quiet) else $error("output after write");
    property p_mask_lat;
        dqm |-> ##2 !dq_dev_oe;
    endproperty
    a_mask_lat: assert property (p_mask_lat) else $error("mask did not silence output");
endmodule : sdr_asserts
